// ---- dvosb_defines.svh ----
// Register offsets, field positions, reset values and widths for the port sideband block
`ifndef DVOSB_DEFINES_SVH
`define DVOSB_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DVOSB_OFS_CTRL 8'h00
`define DVOSB_OFS_STATUS 8'h04
`define DVOSB_OFS_STRAP 8'h08
`define DVOSB_OFS_IRQ_STAT 8'h0c
`define DVOSB_OFS_IRQ_MASK 8'h10
`define DVOSB_OFS_HOLD_CNT 8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DVOSB_CTRL_BORDER_MODE 0
`define DVOSB_CTRL_STALL_MODE 1
`define DVOSB_CTRL_VSTRETCH 2
`define DVOSB_CTRL_BLANK_EN 3
`define DVOSB_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define DVOSB_STAT_PRESENT 0
`define DVOSB_STAT_HOTPLUG 1
`define DVOSB_STAT_FIELD 2
`define DVOSB_STAT_HOLDING 3

// ----------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------
`define DVOSB_IRQ_HP_ASSERT 0
`define DVOSB_IRQ_HP_RELEASE 1
`define DVOSB_IRQ_FIELD 2
`define DVOSB_IRQ_HOLD 3
`define DVOSB_IRQ_W 4
`define DVOSB_IRQ_RESET 4'h0
`define DVOSB_MASK_RESET 4'h0

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DVOSB_STRAP_W 8
`define DVOSB_HOLD_CNT_W 16
`define DVOSB_SYNC_W 2

`endif

// ---- dvosb_pkg.sv ----
// Types shared by the port sideband block
package dvosb_pkg;

    // Line hold sequencer states
    typedef enum logic [0:0] {
        DVOSB_LINE_RUN,
        DVOSB_LINE_HOLD
    } dvosb_line_t;

    // Strap capture states
    typedef enum logic [0:0] {
        DVOSB_STRAP_WAIT,
        DVOSB_STRAP_DONE
    } dvosb_strap_t;

endpackage

// ---- dvosb_sync_if.sv ----
// Carrier between the input synchroniser and the sideband top
`timescale 1ns/1ps
interface dvosb_sync_if;
    logic hp_asserted;
    logic hp_assert_pulse;
    logic hp_release_pulse;
    logic fs_level;
    logic fs_edge_pulse;

    modport src (
        output hp_asserted,
        output hp_assert_pulse,
        output hp_release_pulse,
        output fs_level,
        output fs_edge_pulse
    );

    modport dst (
        input hp_asserted,
        input hp_assert_pulse,
        input hp_release_pulse,
        input fs_level,
        input fs_edge_pulse
    );
endinterface

// ---- dvosb_sync.sv ----
// Two-flop synchronisers and edge detection for the hot-plug and field/stall inputs
`timescale 1ns/1ps
`include "dvosb_defines.svh"
module dvosb_sync
    import dvosb_pkg::*;
#(
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic hotplug_irq_n,
    input wire logic field_or_stall,
    dvosb_sync_if.src sync
);

    // ----------------------------------------------------------------
    // Synchroniser chains
    // ----------------------------------------------------------------
    logic [`DVOSB_SYNC_W-1:0] raw;
    logic [`DVOSB_SYNC_W-1:0] synced;
    logic [`DVOSB_SYNC_W-1:0] prev_r;

    // Hot-plug is active low; idle level after reset is released (high)
    assign raw = {field_or_stall, hotplug_irq_n};

    genvar g;
    generate
        for (g = 0; g < `DVOSB_SYNC_W; g++) begin : g_chain
            logic [STAGES-1:0] chain_r;
            always_ff @(posedge clk) begin
                if (srst) begin
                    chain_r <= (g == 0) ? {STAGES{1'b1}} : {STAGES{1'b0}};
                end else begin
                    chain_r <= {chain_r[STAGES-2:0], raw[g]};
                end
            end
            assign synced[g] = chain_r[STAGES-1];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Edge detection on the last stage only
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            prev_r <= 2'h1;
        end else begin
            prev_r <= synced;
        end
    end

    assign sync.hp_asserted = ~synced[0];
    assign sync.hp_assert_pulse = prev_r[0] & ~synced[0];
    assign sync.hp_release_pulse = ~prev_r[0] & synced[0];
    assign sync.fs_level = synced[1];
    assign sync.fs_edge_pulse = prev_r[1] ^ synced[1];

endmodule

// ---- dvosb_top.sv ----
// Digital video port sideband control: blank indicator, hot-plug, field/stall, straps
//
// Operation
// - Blank mode: indicator output marks active pixels only, border excluded.
// - Border mode: indicator output marks active pixels plus surrounding border.
// - Hot-plug input assertion from display is accepted as an interrupt event.
// - Shared input acts as TV field or panel stall by configured mode.
// - Field mode with interlaced overlay: overlay field follows encoder field input.
// - Stall mode: stall asserted at a line start holds the pixel pipeline for that whole line.
// - Panel fitter uses stall to insert held lines when stretching vertically.
// - Eight-bit identity strap is captured and readable by display firmware.
// - Presence strap low means device attached; high means none present.
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "dvosb_defines.svh"
module dvosb_top
    import dvosb_pkg::*;
#(
    parameter int STRAP_W = `DVOSB_STRAP_W,
    parameter int HOLD_CNT_W = `DVOSB_HOLD_CNT_W
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ,
    input wire logic ACTIVE_PIX,
    input wire logic BORDER_PIX,
    input wire logic LINE_START,
    input wire logic OVL_INTERLACED,
    output logic PORT_BLANK_BORDER_N,
    output logic PIPE_HOLD_LINE,
    output logic PFIT_INSERT_LINE,
    output logic OVL_FIELD,
    output logic OVL_FIELD_RESYNC,
    input wire logic DISPLAY_HOTPLUG_IRQ_N,
    input wire logic FIELD_OR_STALL_IN,
    input wire logic [STRAP_W-1:0] ADDIN_IDENTITY_STRAP,
    input wire logic PORT_PRESENT_STRAP_N
);

    // ----------------------------------------------------------------
    // Register byte-lane merge, used by the control register byte
    // ----------------------------------------------------------------
    function automatic logic [7:0] wb_merge(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic lane
    );
        wb_merge = lane ? new_val : old_val;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    dvosb_sync_if sync_bus ();

    dvosb_sync #(
        .STAGES(2)
    ) u_sync (
        .clk(REF_CLK),
        .srst(SRST),
        .hotplug_irq_n(DISPLAY_HOTPLUG_IRQ_N),
        .field_or_stall(FIELD_OR_STALL_IN),
        .sync(sync_bus)
    );

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [`DVOSB_IRQ_W-1:0] irq_stat_r;
    logic [`DVOSB_IRQ_W-1:0] irq_stat_nxt;
    logic [`DVOSB_IRQ_W-1:0] irq_mask_r;
    logic [`DVOSB_IRQ_W-1:0] irq_set;
    logic [HOLD_CNT_W-1:0] hold_cnt_r;
    logic [STRAP_W-1:0] strap_id_r;
    logic present_r;
    dvosb_strap_t strap_state_r;
    dvosb_line_t line_state_r;
    logic [31:0] rd_data;

    logic border_mode;
    logic stall_mode;
    logic vstretch_en;
    logic blank_en;

    assign border_mode = ctrl_r[`DVOSB_CTRL_BORDER_MODE];
    assign stall_mode = ctrl_r[`DVOSB_CTRL_STALL_MODE];
    assign vstretch_en = ctrl_r[`DVOSB_CTRL_VSTRETCH];
    assign blank_en = ctrl_r[`DVOSB_CTRL_BLANK_EN];

    // ----------------------------------------------------------------
    // Wishbone classic slave
    // ----------------------------------------------------------------
    logic bus_req;
    logic bus_wr;
    logic hit_ctrl;
    logic hit_irq_stat;
    logic hit_irq_mask;
    logic hit_hold_cnt;

    assign bus_req = WB_CYC_I & WB_STB_I;
    // Writes land at the edge where the master samples ack high
    assign bus_wr = bus_req & WB_WE_I & WB_ACK_O;
    assign hit_ctrl = (WB_ADR_I == `DVOSB_OFS_CTRL);
    assign hit_irq_stat = (WB_ADR_I == `DVOSB_OFS_IRQ_STAT);
    assign hit_irq_mask = (WB_ADR_I == `DVOSB_OFS_IRQ_MASK);
    assign hit_hold_cnt = (WB_ADR_I == `DVOSB_OFS_HOLD_CNT);

    // One wait state; ack drops the cycle after it was given
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req & ~WB_ACK_O;
        end
    end

    // Unmapped offsets are acknowledged and read as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (WB_ADR_I)
            `DVOSB_OFS_CTRL: begin
                rd_data[7:0] = ctrl_r;
            end
            `DVOSB_OFS_STATUS: begin
                rd_data[`DVOSB_STAT_PRESENT] = present_r;
                rd_data[`DVOSB_STAT_HOTPLUG] = sync_bus.hp_asserted;
                rd_data[`DVOSB_STAT_FIELD] = sync_bus.fs_level;
                rd_data[`DVOSB_STAT_HOLDING] = (line_state_r == DVOSB_LINE_HOLD);
            end
            `DVOSB_OFS_STRAP: begin
                rd_data[STRAP_W-1:0] = strap_id_r;
            end
            `DVOSB_OFS_IRQ_STAT: begin
                rd_data[`DVOSB_IRQ_W-1:0] = irq_stat_r;
            end
            `DVOSB_OFS_IRQ_MASK: begin
                rd_data[`DVOSB_IRQ_W-1:0] = irq_mask_r;
            end
            `DVOSB_OFS_HOLD_CNT: begin
                rd_data[HOLD_CNT_W-1:0] = hold_cnt_r;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (bus_req & ~WB_ACK_O & ~WB_WE_I) begin
            WB_DAT_O <= rd_data;
        end else begin
            WB_DAT_O <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Control and mask registers
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ctrl_r <= `DVOSB_CTRL_RESET;
        end else if (bus_wr & hit_ctrl) begin
            ctrl_r <= wb_merge(ctrl_r, WB_DAT_I[7:0], WB_SEL_I[0]);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            irq_mask_r <= `DVOSB_MASK_RESET;
        end else if (bus_wr & hit_irq_mask) begin
            irq_mask_r <= WB_SEL_I[0] ? WB_DAT_I[`DVOSB_IRQ_W-1:0]
                : irq_mask_r;
        end
    end

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // Straps are caught once, on the first clock after reset release, so a
    // reset never loads a pin value directly.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            strap_state_r <= DVOSB_STRAP_WAIT;
            strap_id_r <= '0;
            present_r <= 1'b0;
        end else begin
            case (strap_state_r)
                DVOSB_STRAP_WAIT: begin
                    strap_id_r <= ADDIN_IDENTITY_STRAP;
                    present_r <= ~PORT_PRESENT_STRAP_N;
                    strap_state_r <= DVOSB_STRAP_DONE;
                end
                DVOSB_STRAP_DONE: begin
                    strap_state_r <= DVOSB_STRAP_DONE;
                end
                default: begin
                    strap_state_r <= DVOSB_STRAP_WAIT;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Blank / border indicator
    // ----------------------------------------------------------------
    // Registered so it leaves on the same pixel edge as the data it qualifies;
    // upstream pixel data carries the same one-cycle stage.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            PORT_BLANK_BORDER_N <= 1'b1;
        end else if (!blank_en) begin
            PORT_BLANK_BORDER_N <= 1'b1;
        end else if (border_mode) begin
            PORT_BLANK_BORDER_N <= ~(ACTIVE_PIX | BORDER_PIX);
        end else begin
            PORT_BLANK_BORDER_N <= ~(ACTIVE_PIX & ~BORDER_PIX);
        end
    end

    // ----------------------------------------------------------------
    // Line hold sequencer (stall mode)
    // ----------------------------------------------------------------
    logic stall_seen;

    // The panel moves stall only in blanking, so the level sampled at the
    // line start is stable for the whole line that follows.
    assign stall_seen = stall_mode & sync_bus.fs_level & LINE_START;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            line_state_r <= DVOSB_LINE_RUN;
        end else begin
            case (line_state_r)
                DVOSB_LINE_RUN: begin
                    if (stall_seen) begin
                        line_state_r <= DVOSB_LINE_HOLD;
                    end
                end
                DVOSB_LINE_HOLD: begin
                    // One line per request; a still-high stall holds the next one
                    if (LINE_START && !stall_seen) begin
                        line_state_r <= DVOSB_LINE_RUN;
                    end
                end
                default: begin
                    line_state_r <= DVOSB_LINE_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            PIPE_HOLD_LINE <= 1'b0;
        end else if (LINE_START) begin
            PIPE_HOLD_LINE <= stall_seen;
        end
    end

    // Panel fitter inserts a held line only while stretching vertically
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            PFIT_INSERT_LINE <= 1'b0;
        end else begin
            PFIT_INSERT_LINE <= stall_seen & vstretch_en;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            hold_cnt_r <= '0;
        end else if (bus_wr & hit_hold_cnt) begin
            hold_cnt_r <= '0;
        end else if (stall_seen) begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Overlay field tracking (field mode)
    // ----------------------------------------------------------------
    logic field_track;

    assign field_track = ~stall_mode & OVL_INTERLACED;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            OVL_FIELD <= 1'b0;
        end else if (field_track) begin
            OVL_FIELD <= sync_bus.fs_level;
        end
    end

    // Pulses when the overlay must realign, including on entering tracking
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            OVL_FIELD_RESYNC <= 1'b0;
        end else begin
            OVL_FIELD_RESYNC <= field_track & (OVL_FIELD != sync_bus.fs_level);
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    always_comb begin
        irq_set = '0;
        irq_set[`DVOSB_IRQ_HP_ASSERT] = sync_bus.hp_assert_pulse;
        irq_set[`DVOSB_IRQ_HP_RELEASE] = sync_bus.hp_release_pulse;
        irq_set[`DVOSB_IRQ_FIELD] = field_track & sync_bus.fs_edge_pulse;
        irq_set[`DVOSB_IRQ_HOLD] = stall_seen;
    end

    // Write-one-to-clear; an event in the clearing cycle survives
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (bus_wr & hit_irq_stat & WB_SEL_I[0]) begin
            irq_stat_nxt = irq_stat_r & ~WB_DAT_I[`DVOSB_IRQ_W-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | irq_set;
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            irq_stat_r <= `DVOSB_IRQ_RESET;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_nxt & irq_mask_r);
        end
    end

endmodule

// ---- dvosb_top_checker.sv ----
// Concurrent checks on the port sideband block top ports
`timescale 1ns/1ps
module dvosb_top_checker (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic ACTIVE_PIX,
    input wire logic BORDER_PIX,
    input wire logic LINE_START,
    input wire logic PORT_BLANK_BORDER_N,
    input wire logic PIPE_HOLD_LINE,
    input wire logic PFIT_INSERT_LINE,
    input wire logic FIELD_OR_STALL_IN
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    property p_ack_pulse;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_answer;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack not one cycle after request");
    property p_rd_idle;
        !WB_ACK_O |-> WB_DAT_O == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data nonzero without ack");

    // ----------------------------------------------------------------
    // Indicator and line hold
    // ----------------------------------------------------------------
    property p_blank_idle;
        !ACTIVE_PIX && !BORDER_PIX |=> PORT_BLANK_BORDER_N;
    endproperty
    a_blank_idle: assert property (p_blank_idle) else $error("low off image");
    property p_hold_rise;
        $rose(PIPE_HOLD_LINE) |-> $past(LINE_START);
    endproperty
    a_hold_rise: assert property (p_hold_rise) else $error("hold began off line start");
    property p_hold_keep;
        PIPE_HOLD_LINE && !LINE_START |=> PIPE_HOLD_LINE;
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("hold dropped inside line");
    property p_pfit_hold;
        PFIT_INSERT_LINE |-> PIPE_HOLD_LINE && $past(LINE_START);
    endproperty
    a_pfit_hold: assert property (p_pfit_hold) else $error("insert without held line");
    property p_hold_stall;
        $rose(PIPE_HOLD_LINE) |-> $past(FIELD_OR_STALL_IN, 3);
    endproperty
    a_hold_stall: assert property (p_hold_stall) else $error("hold without stall");

    c_hold: cover property ($rose(PIPE_HOLD_LINE));
    c_pfit: cover property (PFIT_INSERT_LINE);
    c_ack: cover property (WB_ACK_O && WB_CYC_I);
endmodule

bind dvosb_top dvosb_top_checker u_chk (
    .REF_CLK(REF_CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ACTIVE_PIX(ACTIVE_PIX),
    .BORDER_PIX(BORDER_PIX), .LINE_START(LINE_START),
    .PORT_BLANK_BORDER_N(PORT_BLANK_BORDER_N), .PIPE_HOLD_LINE(PIPE_HOLD_LINE),
    .PFIT_INSERT_LINE(PFIT_INSERT_LINE), .FIELD_OR_STALL_IN(FIELD_OR_STALL_IN)
);

// ---- dvosb_panel_model.sv ----
// Model of the external encoder or panel on the port sideband pins
`timescale 1ns/1ps
module dvosb_panel_model #(
    parameter logic [7:0] STRAP_VAL = 8'h5a
) (
    input wire logic clk,
    input wire logic line_start,
    input wire logic stall_mode,
    input wire logic plug_req,
    input wire logic field_req,
    input wire logic stall_req,
    output logic hotplug_n,
    output logic field_or_stall,
    output logic [7:0] strap,
    output logic present_n
);
    logic held_r;

    // A fitted device forces the top strap bit low
    assign strap = {1'b0, STRAP_VAL[6:0]};
    assign present_n = 1'b0;
    assign hotplug_n = !plug_req;
    // Panel moves its stall level only at a line boundary; an encoder at any time
    always_ff @(posedge clk) begin
        if (line_start) begin
            held_r <= stall_req;
        end
    end
    assign field_or_stall = stall_mode ? held_r : field_req;
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the port sideband block
`timescale 1ns/1ps
`include "dvosb_defines.svh"
module tb_top;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, irq, blank_n, hold, pfit, ovl_field, resync, hp_n, fs, pres_n;
    logic [7:0] strap;
    logic active_pix = 1'b0;
    logic border_pix = 1'b0;
    logic line_start = 1'b0;
    logic ovl_il = 1'b0;
    logic stall_mode = 1'b0;
    logic plug_req = 1'b0;
    logic field_req = 1'b0;
    logic stall_req = 1'b0;
    logic [3:0] pix_cnt = 4'h0;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    always #20 ref_clk = ~ref_clk;

    dvosb_top dut (
        .REF_CLK(ref_clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .IRQ(irq), .ACTIVE_PIX(active_pix), .BORDER_PIX(border_pix),
        .LINE_START(line_start), .OVL_INTERLACED(ovl_il), .PORT_BLANK_BORDER_N(blank_n),
        .PIPE_HOLD_LINE(hold), .PFIT_INSERT_LINE(pfit), .OVL_FIELD(ovl_field),
        .OVL_FIELD_RESYNC(resync), .DISPLAY_HOTPLUG_IRQ_N(hp_n), .FIELD_OR_STALL_IN(fs),
        .ADDIN_IDENTITY_STRAP(strap), .PORT_PRESENT_STRAP_N(pres_n)
    );
    dvosb_panel_model u_panel (
        .clk(ref_clk), .line_start(line_start), .stall_mode(stall_mode),
        .plug_req(plug_req), .field_req(field_req), .stall_req(stall_req),
        .hotplug_n(hp_n), .field_or_stall(fs), .strap(strap), .present_n(pres_n)
    );

    // ----------------------------------------------------------------
    // Line timing: 16-cycle lines, border on 2 cycles each side of 8 active
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        pix_cnt <= pix_cnt + 4'h1;
        line_start <= (pix_cnt == 4'hf);
        border_pix <= (pix_cnt inside {[4'h1:4'h2], [4'hb:4'hc]});
        active_pix <= (pix_cnt >= 4'h3) && (pix_cnt <= 4'ha);
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        check(what, exp, r & m);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd_chk("ctrl", `DVOSB_OFS_CTRL, 32'hff, 32'h0);
        rd_chk("mask", `DVOSB_OFS_IRQ_MASK, 32'hf, 32'h0);
        rd_chk("stat", `DVOSB_OFS_IRQ_STAT, 32'hf, 32'h0);
        wr(8'h3c, 32'hff);
        rd_chk("unmapped", 8'h3c, 32'hffffffff, 32'h0);
        rd_chk("strap", `DVOSB_OFS_STRAP, 32'hff, 32'h5a);
        rd_chk("present", `DVOSB_OFS_STATUS, 32'h1, 32'h1);
        $display("test regs done");
    endtask

    task automatic t_indicator();
        logic [7:0] modes [3];
        logic a, b, e;
        modes = '{8'h00, 8'h08, 8'h09};
        for (int i = 0; i < 3; i++) begin
            wr(`DVOSB_OFS_CTRL, {24'h0, modes[i]});
            repeat (32) begin
                @(posedge ref_clk);
                a = active_pix;
                b = border_pix;
                #1;
                e = (i == 0) ? 1'b1 : (i == 1) ? !(a && !b) : !(a || b);
                check("blank_n", {31'h0, e}, {31'h0, blank_n});
            end
        end
        wr(`DVOSB_OFS_CTRL, 32'h0);
        $display("test indicator done");
    endtask

    task automatic t_hotplug();
        wr(`DVOSB_OFS_IRQ_MASK, 32'h1);
        plug_req <= 1'b1;
        for (int n = 0; n < 10 && irq !== 1'b1; n++) @(posedge ref_clk);
        check("irq raised", 32'h1, {31'h0, irq});
        rd_chk("hp stat", `DVOSB_OFS_IRQ_STAT, 32'hf, 32'h1);
        wr(`DVOSB_OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge ref_clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        plug_req <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check("irq masked", 32'h0, {31'h0, irq});
        rd_chk("unplug stat", `DVOSB_OFS_IRQ_STAT, 32'hf, 32'h2);
        wr(`DVOSB_OFS_IRQ_STAT, 32'h2);
        rd_chk("stat clear", `DVOSB_OFS_IRQ_STAT, 32'hf, 32'h0);
        $display("test hotplug done");
    endtask

    task automatic t_field();
        ovl_il <= 1'b1;
        wr(`DVOSB_OFS_IRQ_MASK, 32'h4);
        field_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check("resync", 32'h1, {31'h0, resync});
        check("field high", 32'h1, {31'h0, ovl_field});
        check("field irq", 32'h1, {31'h0, irq});
        field_req <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check("field low", 32'h0, {31'h0, ovl_field});
        wr(`DVOSB_OFS_IRQ_STAT, 32'h4);
        wr(`DVOSB_OFS_IRQ_MASK, 32'h0);
        ovl_il <= 1'b0;
        $display("test field done");
    endtask

    task automatic t_stall();
        int hc, pc, n;
        hc = 0;
        pc = 0;
        stall_mode <= 1'b1;
        wr(`DVOSB_OFS_CTRL, 32'h6);
        wr(`DVOSB_OFS_HOLD_CNT, 32'h0);
        stall_req <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (line_start !== 1'b1 && n < 40);
        stall_req <= 1'b0;
        repeat (64) begin
            @(posedge ref_clk);
            hc += (hold === 1'b1);
            pc += (pfit === 1'b1);
        end
        check("held cycles", 32'd16, hc);
        check("inserts", 32'd1, pc);
        rd_chk("hold cnt", `DVOSB_OFS_HOLD_CNT, 32'hffff, 32'h1);
        rd_chk("hold stat", `DVOSB_OFS_IRQ_STAT, 32'hf, 32'h8);
        wr(`DVOSB_OFS_HOLD_CNT, 32'h0);
        rd_chk("cnt clear", `DVOSB_OFS_HOLD_CNT, 32'hffff, 32'h0);
        wr(`DVOSB_OFS_IRQ_STAT, 32'h8);
        wr(`DVOSB_OFS_CTRL, 32'h0);
        stall_mode <= 1'b0;
        $display("test stall done");
    endtask

    task automatic finish_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_indicator();
        t_hotplug();
        t_field();
        t_stall();
        finish_test();
    end
endmodule
